// file: hw/dac_host_pkg.sv
// constants, types and the start-up table layout for the dac start-up host
// assumes a 250 MHz system clock and a 3-wire serial port on the converter
package dac_host_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS        = 4;     // system clock period
    localparam int SCLK_HALF_NS  = 20;    // least half period of serial clk
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] DIV_RELOAD = 4'(SCLK_HALF_CYC - 1);

    // ------------------------------------------------------------------
    // serial frame: {rw, 7'h0, addr[7:0]} then one data byte, msb first
    // ------------------------------------------------------------------
    localparam int         FRAME_BITS = 24;
    localparam int         INSTR_BITS = 16;
    localparam logic [4:0] LAST_BIT   = 5'(FRAME_BITS - 1);
    localparam logic [4:0] INSTR_LAST = 5'(INSTR_BITS - 1);
    localparam int         DONE_BIT   = 1;   // completion bit of polled regs

    // ------------------------------------------------------------------
    // converter register addresses and values
    // ------------------------------------------------------------------
    localparam logic [7:0] DEV_COMMON    = 8'h00;
    localparam logic [7:0] DEV_PWR_DOWN  = 8'h01;
    localparam logic [7:0] DEV_START_A   = 8'h20;
    localparam logic [7:0] DEV_START_B   = 8'h79;
    localparam logic [7:0] DEV_START_C   = 8'h80;
    localparam logic [7:0] DEV_START_D   = 8'he1;
    localparam logic [7:0] DEV_PLL_CTRL  = 8'h12;
    localparam logic [7:0] DEV_PLL_LOOP  = 8'h14;
    localparam logic [7:0] DEV_PLL_DIV   = 8'h15;
    localparam logic [7:0] DEV_FIFO_STAT = 8'h24;
    localparam logic [7:0] DEV_FIFO_CTRL = 8'h25;
    localparam logic [7:0] DEV_DATAPATH  = 8'h27;
    localparam logic [7:0] DEV_INTERP    = 8'h28;
    localparam logic [7:0] DEV_NCO_UPD   = 8'h30;
    localparam logic [7:0] DEV_TUNE0     = 8'h31;
    localparam logic [7:0] DEV_TUNE1     = 8'h32;
    localparam logic [7:0] DEV_TUNE2     = 8'h33;
    localparam logic [7:0] DEV_TUNE3     = 8'h34;
    localparam logic [7:0] DEV_DLY       = 8'h5e;
    localparam logic [7:0] DEV_DLY_CTRL  = 8'h5f;

    localparam logic [7:0] VAL_SOFT_RST  = 8'h20;
    localparam logic [7:0] VAL_START_A   = 8'h01;
    localparam logic [7:0] VAL_START_B   = 8'h18;
    localparam logic [7:0] VAL_START_C   = 8'had;
    localparam logic [7:0] VAL_START_D   = 8'h1a;
    localparam logic [7:0] VAL_LOOP      = 8'he3;
    localparam logic [7:0] VAL_PLL_MAN   = 8'hc0;
    localparam logic [7:0] VAL_PLL_AUTO  = 8'h80;
    localparam logic [7:0] VAL_DLY_EN    = 8'h08;
    localparam logic [7:0] VAL_FIFO_RST  = 8'h01;
    localparam logic [7:0] VAL_NCO_EN    = 8'h40;
    localparam logic [7:0] VAL_NCO_SINC  = 8'hc0;
    localparam logic [7:0] VAL_NCO_UPD   = 8'h01;
    localparam logic [7:0] VAL_PWR_UP    = 8'h00;
    localparam logic [7:0] FIFO_OK0      = 8'h37;
    localparam logic [7:0] FIFO_OK1      = 8'h40;
    localparam logic [7:0] FIFO_OK2      = 8'h41;

    localparam logic [4:0] STEP_FIFO_CHK = 5'd14;
    localparam logic [4:0] STEP_LAST     = 5'd23;

    // ------------------------------------------------------------------
    // host register map (apb byte offsets) and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_TUNE     = 8'h08;
    localparam logic [7:0]  OFS_SETUP    = 8'h0c;
    localparam logic [7:0]  OFS_DIRECT   = 8'h10;
    localparam logic [31:0] RST_TUNE     = 32'h38000000;
    localparam logic [23:0] RST_SETUP    = 24'h0300c2; // interp,dly,div

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_SHIFT = 2'b10,
        ST_EVAL  = 2'b11
    } state_e;

    typedef enum logic [1:0] {
        OP_WR    = 2'b00,
        OP_POLL  = 2'b01,
        OP_CHECK = 2'b10,
        OP_RD    = 2'b11
    } op_e;

    typedef struct packed {
        op_e        op;
        logic [7:0] addr;
        logic [7:0] data;
    } step_s;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic sdo;
        logic oe;
    } spi_pins_s;

endpackage

// file: hw/dac_start_host.sv
// host that brings a dual high-speed converter up over its 3-wire port
// assumes sdioIn synchronous to clk; software drives it over apb
`timescale 1ns/1ps
module dac_start_host
    import dac_host_pkg::*;
#(
    parameter logic [15:0] POLL_MAX = 16'd256  // read attempts per poll
) (
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire apb_req_s  apbReq,
    output apb_rsp_s       apbRsp,
    output spi_pins_s      spiPins,
    input  wire logic      sdioIn
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rstPipe;   // two-stage release of async reset
    logic       rstnSync;  // released reset for the rest of the block

    // async assert, sync release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstnSync = rstPipe[1];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        state_e      state;
        logic [4:0]  step;      // index into the start-up table
        logic        direct;    // single access, not the table
        logic [4:0]  bitCnt;    // bit of frame in flight
        logic [3:0]  divCnt;    // half-period divider
        logic [23:0] shift;     // outgoing frame
        logic        reading;   // frame is a read
        logic [7:0]  rdData;    // captured read byte
        logic [15:0] pollCnt;   // reads spent on current poll
        logic        busy;
        logic        done;
        logic        timeout;
        logic        fifoFault;
        logic [31:0] tune;      // tuning word to load
        logic [23:0] setup;     // interp, delay, divider values
        logic [15:0] dirReg;    // direct data, direct address
        apb_rsp_s    rsp;
        spi_pins_s   pins;
    } state_s;

    state_s s;  // registered state
    state_s n;  // next state
    step_s  cur; // step being issued

    // ------------------------------------------------------------------
    // start-up table
    // ------------------------------------------------------------------
    // fixed order; only the values software may tune come from registers
    function automatic step_s stepAt(input logic [4:0]  idx,
                                     input logic [31:0] tw,
                                     input logic [23:0] su);
        case (idx)
            5'd0:  stepAt = '{OP_WR, DEV_COMMON, VAL_SOFT_RST};
            5'd1:  stepAt = '{OP_WR, DEV_START_A, VAL_START_A};
            5'd2:  stepAt = '{OP_WR, DEV_START_B, VAL_START_B};
            5'd3:  stepAt = '{OP_WR, DEV_START_C, VAL_START_C};
            5'd4:  stepAt = '{OP_WR, DEV_START_D, VAL_START_D};
            5'd5:  stepAt = '{OP_WR, DEV_PLL_LOOP, VAL_LOOP};
            5'd6:  stepAt = '{OP_WR, DEV_PLL_DIV, su[7:0]};
            5'd7:  stepAt = '{OP_WR, DEV_PLL_CTRL, VAL_PLL_MAN};
            5'd8:  stepAt = '{OP_WR, DEV_PLL_CTRL, VAL_PLL_AUTO};
            5'd9:  stepAt = '{OP_WR, DEV_DLY, su[15:8]};
            5'd10: stepAt = '{OP_WR, DEV_DLY_CTRL, VAL_DLY_EN};
            5'd11: stepAt = '{OP_WR, DEV_INTERP, su[23:16]};
            5'd12: stepAt = '{OP_WR, DEV_FIFO_CTRL, VAL_FIFO_RST};
            5'd13: stepAt = '{OP_POLL, DEV_FIFO_CTRL, 8'h00};
            5'd14: stepAt = '{OP_CHECK, DEV_FIFO_STAT, 8'h00};
            5'd15: stepAt = '{OP_WR, DEV_DATAPATH, VAL_NCO_EN};
            5'd16: stepAt = '{OP_WR, DEV_TUNE0, tw[7:0]};
            5'd17: stepAt = '{OP_WR, DEV_TUNE1, tw[15:8]};
            5'd18: stepAt = '{OP_WR, DEV_TUNE2, tw[23:16]};
            5'd19: stepAt = '{OP_WR, DEV_TUNE3, tw[31:24]};
            5'd20: stepAt = '{OP_WR, DEV_NCO_UPD, VAL_NCO_UPD};
            5'd21: stepAt = '{OP_POLL, DEV_NCO_UPD, 8'h00};
            5'd22: stepAt = '{OP_WR, DEV_DATAPATH, VAL_NCO_SINC};
            default: stepAt = '{OP_WR, DEV_PWR_DOWN, VAL_PWR_UP};
        endcase
    endfunction

    // apb address decode, used for the error answer and for writes
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_TUNE) ||
                 (a == OFS_SETUP) || (a == OFS_DIRECT);
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        n = s;
        // direct access overrides the table entry
        if (s.direct) begin
            cur = '{(s.reading ? OP_RD : OP_WR), s.dirReg[7:0],
                    s.dirReg[15:8]};
        end else begin
            cur = stepAt(s.step, s.tune, s.setup);
        end

        // apb slave: answer registered in setup, so one access cycle
        n.rsp.pready  = 1'b0;
        n.rsp.pslverr = 1'b0;
        if (apbReq.psel && !apbReq.penable) begin
            n.rsp.pready  = 1'b1;
            n.rsp.pslverr = !mapped(apbReq.paddr);
            n.rsp.prdata  = 32'h0;
            if (!apbReq.pwrite) begin
                case (apbReq.paddr)
                    OFS_STATUS: n.rsp.prdata = {8'h00, s.rdData, 3'b000,
                        s.step, 4'h0, s.fifoFault, s.timeout, s.done,
                        s.busy};
                    OFS_TUNE:   n.rsp.prdata = s.tune;
                    OFS_SETUP:  n.rsp.prdata = {8'h00, s.setup};
                    OFS_DIRECT: n.rsp.prdata = {16'h0, s.dirReg};
                    default:    n.rsp.prdata = 32'h0;
                endcase
            end
        end
        // writes take effect at the completing edge only
        if (apbReq.psel && apbReq.penable && s.rsp.pready &&
            apbReq.pwrite && mapped(apbReq.paddr)) begin
            case (apbReq.paddr)
                OFS_TUNE:   n.tune   = apbReq.pwdata;
                OFS_SETUP:  n.setup  = apbReq.pwdata[23:0];
                OFS_DIRECT: n.dirReg = apbReq.pwdata[15:0];
                OFS_CTRL: begin
                    // commands while busy are dropped; order cannot be broken
                    if (!s.busy && (apbReq.pwdata[2:0] != 3'b000)) begin
                        n.busy      = 1'b1;
                        n.done      = 1'b0;
                        n.timeout   = 1'b0;
                        n.fifoFault = 1'b0;
                        n.step      = 5'd0;
                        n.pollCnt   = 16'd0;
                        n.direct    = !apbReq.pwdata[0];
                        // direct read picks the frame kind; bit2 beats bit1
                        n.reading   = !apbReq.pwdata[0] && apbReq.pwdata[2];
                        n.state     = ST_FETCH;
                    end
                end
                default: begin
                    // status is read only
                end
            endcase
        end

        // sequencer and serial engine
        case (s.state)
            ST_IDLE: begin
                n.pins.csN = 1'b1;
            end
            ST_FETCH: begin
                // open a frame: chip select low, first bit on the wire
                n.reading = (cur.op != OP_WR);
                n.shift   = {(cur.op != OP_WR), 7'h00, cur.addr, cur.data};
                n.pins.sdo  = (cur.op != OP_WR);
                n.pins.oe   = 1'b1;
                n.pins.csN  = 1'b0;
                n.pins.sclk = 1'b0;
                n.bitCnt  = 5'd0;
                n.divCnt  = DIV_RELOAD;
                n.state   = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (s.divCnt != 4'd0) begin
                    n.divCnt = s.divCnt - 4'd1;
                end else begin
                    n.divCnt = DIV_RELOAD;
                    if (!s.pins.sclk) begin
                        // rising edge: converter samples, host samples data
                        n.pins.sclk = 1'b1;
                        if (s.reading && (s.bitCnt > INSTR_LAST)) begin
                            n.rdData = {s.rdData[6:0], sdioIn};
                        end
                    end else begin
                        n.pins.sclk = 1'b0;
                        if (s.bitCnt == LAST_BIT) begin
                            n.pins.csN = 1'b1;
                            n.pins.oe  = 1'b0;
                            n.state    = ST_EVAL;
                        end else begin
                            n.bitCnt   = s.bitCnt + 5'd1;
                            n.shift    = {s.shift[22:0], 1'b0};
                            n.pins.sdo = s.shift[22];
                            // turn the line round for the data byte of a read
                            if (s.reading && (s.bitCnt == INSTR_LAST)) begin
                                n.pins.oe = 1'b0;
                            end
                        end
                    end
                end
            end
            ST_EVAL: begin
                n.state = ST_FETCH;
                if ((cur.op == OP_POLL) && !s.rdData[DONE_BIT]) begin
                    // completion not seen yet: retry, but only so often
                    if (s.pollCnt == POLL_MAX - 16'd1) begin
                        n.timeout = 1'b1;
                        n.busy    = 1'b0;
                        n.state   = ST_IDLE;
                    end else begin
                        n.pollCnt = s.pollCnt + 16'd1;
                    end
                end else if ((cur.op == OP_CHECK) &&
                             (s.rdData != FIFO_OK0) &&
                             (s.rdData != FIFO_OK1) &&
                             (s.rdData != FIFO_OK2)) begin
                    n.fifoFault = 1'b1;
                    n.busy      = 1'b0;
                    n.state     = ST_IDLE;
                end else if (s.direct || (s.step == STEP_LAST)) begin
                    n.done  = 1'b1;
                    n.busy  = 1'b0;
                    n.state = ST_IDLE;
                end else begin
                    n.step    = s.step + 5'd1;
                    n.pollCnt = 16'd0;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            s       <= '0;
            s.state <= ST_IDLE;
            s.tune  <= RST_TUNE;
            s.setup <= RST_SETUP;
            s.pins.csN <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign apbRsp  = s.rsp;
    assign spiPins = s.pins;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstnSync);

    chk_select_idle: assert property (!s.busy |-> s.pins.csN)
        else $error("chip select active while idle");
    chk_clock_parked: assert property (s.pins.csN |-> !s.pins.sclk)
        else $error("serial clock high outside a frame");
    chk_step_order: assert property (
        (s.busy && $past(s.busy) && $changed(s.step)) |->
        (s.step == $past(s.step) + 5'd1))
        else $error("start-up step skipped or reordered");
    chk_start_reset: assert property (
        ($rose(s.busy) && !s.direct) |-> (s.step == 5'd0) ##1
        (s.shift == {8'h00, DEV_COMMON, VAL_SOFT_RST}))
        else $error("sequence did not open with soft reset");
    chk_poll_bound: assert property (s.pollCnt < POLL_MAX)
        else $error("poll count beyond its limit");
    chk_timeout_poll: assert property (
        $rose(s.timeout) |-> (s.step == 5'd13 || s.step == 5'd21))
        else $error("timeout outside a polling step");
    chk_fifo_fault: assert property (
        $rose(s.fifoFault) |-> (s.step == STEP_FIFO_CHK) &&
        ($past(s.rdData) != FIFO_OK0) && ($past(s.rdData) != FIFO_OK1) &&
        ($past(s.rdData) != FIFO_OK2))
        else $error("fifo fault without a bad status read");
    chk_read_release: assert property (
        (s.reading && !s.pins.csN && s.bitCnt > INSTR_LAST) |->
        !s.pins.oe)
        else $error("host drives the line during read data");
    chk_done_last: assert property (
        ($rose(s.done) && !s.direct) |-> (s.step == STEP_LAST) &&
        ($past(s.state) == ST_EVAL) && !s.busy)
        else $error("done raised before the last step");
    chk_apb_answer: assert property (
        (apbReq.psel && !apbReq.penable) |=> s.rsp.pready ##1 !s.rsp.pready)
        else $error("apb answer not one cycle");

    cov_sequence_done: cover property ($rose(s.done) && !s.direct);
    cov_poll_timeout:  cover property ($rose(s.timeout));
    cov_fifo_fault:    cover property ($rose(s.fifoFault));
    cov_direct_read:   cover property ($rose(s.done) && s.direct && s.reading);

endmodule

// file: tb/dac_dev_model.sv
// ----------------------------------------
// converter register port model, 3-wire
// ----------------------------------------
// assumes frames {rw,7'h0,addr,data} msb first, sclk idle low
`timescale 1ns/1ps
module dac_dev_model
    import dac_host_pkg::*;
(
    input  wire spi_pins_s  pins,
    input  wire logic [7:0] fifoStat,
    input  wire logic [7:0] pollDelay,
    output logic            sdioIn
);
    logic [7:0]  mem [256];     // register file
    int          rdCnt [256];   // reads since last write
    logic [7:0]  logA [64];     // write log, inspected by the bench
    logic [7:0]  logD [64];
    int          nLog = 0;
    logic [22:0] sh;            // bits taken so far
    int          cnt;           // rising edges in this frame
    logic        rwBit;         // first bit of frame
    logic [7:0]  rdByte;        // byte returned by a read
    logic        drv = 1'b0;
    logic        devOe = 1'b0;
    logic [7:0]  curA;          // last eight bits incl. this one
    assign curA = {sh[6:0], pins.sdo};
    // take bits on sclk rise; csN high aborts the frame
    always @(posedge pins.sclk or posedge pins.csN) begin
        if (pins.csN) begin
            cnt <= 0;
        end else begin
            sh <= {sh[21:0], pins.sdo};
            cnt <= cnt + 1;
            if (cnt == 0) begin
                rwBit <= pins.sdo;
            end
            if (cnt == 15 && sh[14]) begin
                rdCnt[curA] <= rdCnt[curA] + 1;
                rdByte <= mem[curA];
                if (curA == 8'h24) begin
                    rdByte <= fifoStat;
                end else if ((curA == 8'h25 || curA == 8'h30)
                             && rdCnt[curA] >= pollDelay) begin
                    // completion shows only after a slow start
                    rdByte <= mem[curA] | 8'h02;
                end
            end
            if (cnt == 23 && !sh[22]) begin
                // plain store covers pll, delay, interp, fifo, datapath, nco, tune
                mem[sh[14:7]] <= curA;
                rdCnt[sh[14:7]] <= 0;
                logA[nLog] <= sh[14:7];
                logD[nLog] <= curA;
                nLog <= nLog + 1;
            end
        end
    end
    // read data changes on sclk fall, released after bit 23
    always @(negedge pins.sclk or posedge pins.csN) begin
        if (pins.csN) begin
            devOe <= 1'b0;
        end else begin
            devOe <= rwBit && cnt >= 16 && cnt <= 23;
            if (cnt >= 16 && cnt <= 23) begin
                drv <= rdByte[23-cnt];
            end
        end
    end
    // no pull on the wire: undriven shows inverse of last bit
    assign sdioIn = pins.oe ? pins.sdo : (devOe ? drv : ~drv);
endmodule

// file: tb/test_dac_start_host.sv
// ----------------------------------------
// self-checking bench of the start-up host
// ----------------------------------------
// assumes dac_dev_model answers the host's serial frames
`timescale 1ns/1ps
module test_dac_start_host;
    import dac_host_pkg::*;
    localparam logic [15:0] POLLS = 16'd4;       // short poll budget
    localparam logic [23:0] SU    = 24'h0307c2;
    localparam logic [31:0] TW    = 32'h38a1b2c4; // bytes all differ
    localparam logic [7:0]  EXPA [21] = '{8'h00, 8'h20, 8'h79, 8'h80,
        8'he1, 8'h14, 8'h15, 8'h12, 8'h12, 8'h5e, 8'h5f, 8'h28, 8'h25,
        8'h27, 8'h31, 8'h32, 8'h33, 8'h34, 8'h30, 8'h27, 8'h01};
    logic        clk;
    logic        rstn;
    apb_req_s    apbReq;
    apb_rsp_s    apbRsp;
    spi_pins_s   spiPins;
    logic        sdioIn;
    logic [7:0]  fifoStat;
    logic [7:0]  pollDelay;
    logic [31:0] rd;            // last read data
    logic        err;           // last slave error
    logic [7:0]  expD [21];     // expected write data
    int          n_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    dac_start_host #(
        .POLL_MAX (POLLS)
    ) dut (
        .clk     (clk),
        .rstn    (rstn),
        .apbReq  (apbReq),
        .apbRsp  (apbRsp),
        .spiPins (spiPins),
        .sdioIn  (sdioIn)
    );
    dac_dev_model dev (
        .pins      (spiPins),
        .fifoStat  (fifoStat),
        .pollDelay (pollDelay),
        .sdioIn    (sdioIn)
    );
    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", w, e, g);
            n_errors++;
        end
    endtask
    // one apb transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        apbReq <= '{paddr:a, psel:1'b1, penable:1'b0, pwrite:wr, pwdata:d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do @(posedge clk); while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // issue a command, then poll status until busy drops
    task automatic start(input logic [31:0] cmd);
        dev.nLog = 0;
        apb(1'b1, OFS_CTRL, cmd);
        repeat (4) @(posedge clk);
        do apb(1'b0, OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task automatic check_log(input int n);
        chk("writes", n, dev.nLog);
        for (int i = 0; i < n; i++) begin
            chk("addr", {24'h0, EXPA[i]}, {24'h0, dev.logA[i]});
            chk("data", {24'h0, expD[i]}, {24'h0, dev.logD[i]});
        end
    endtask
    task automatic test_regs();
        apb(1'b0, OFS_TUNE, 32'h0);
        chk("tune", 32'h38000000, rd);
        apb(1'b0, OFS_SETUP, 32'h0);
        chk("setup", 32'h000300c2, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, OFS_TUNE, TW);
        apb(1'b1, OFS_SETUP, {8'h0, SU});
    endtask
    task automatic test_full(input logic [7:0] fs);
        fifoStat <= fs;
        start(32'h1);
        chk("done", 32'h00030002, rd & 32'h00ff000f);
        check_log(21);
        chk("fifo polls", 32'd3, dev.rdCnt[8'h25]);
        chk("tune polls", 32'd3, dev.rdCnt[8'h30]);
    endtask
    task automatic test_stop(input logic [7:0] fs, input logic [7:0] pd,
                             input logic [31:0] st);
        fifoStat <= fs;
        pollDelay <= pd;
        start(32'h1);
        chk("stop", st, rd & 32'h00ff000d);
        check_log(13);
        pollDelay <= 8'd2;
    endtask
    task automatic test_direct(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, OFS_DIRECT, {16'h0, d, a});
        start(32'h2);
        chk("dir addr", {24'h0, a}, {24'h0, dev.logA[0]});
        chk("dir data", {24'h0, d}, {24'h0, dev.logD[0]});
        start(32'h4);
        chk("dir read", {8'h0, d, 16'h0}, rd & 32'h00ff000d);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard: a full run needs well under this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        rstn = 1'b0;
        apbReq = '0;
        fifoStat = 8'h40;
        pollDelay = 8'd2;
        expD = '{8'h20, 8'h01, 8'h18, 8'had, 8'h1a, 8'he3, SU[7:0],
            8'hc0, 8'h80, SU[15:8], 8'h08, SU[23:16], 8'h01, 8'h40,
            TW[7:0], TW[15:8], TW[23:16], TW[31:24], 8'h01, 8'hc0, 8'h00};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        test_regs();
        test_full(8'h37);
        test_full(8'h40);
        test_full(8'h41);
        test_stop(8'h55, 8'd2, 32'h00550008);
        test_stop(8'h40, 8'd9, 32'h00010004);
        chk("timeout polls", {16'h0, POLLS}, dev.rdCnt[8'h25]);
        test_direct(8'h3b, 8'ha5);
        test_direct(8'h37, 8'h5c);
        print_verdict();
    end
endmodule
